// ### test/seac_ee_model.sv
// Behavioural serial EEPROM on the far side of the link
`timescale 1ns/1ps
module seac_ee_model (
  // Serial link
  input  wire logic sck,
  input  wire logic cs_n,
  input  wire logic mosi,
  output logic      miso
);
  logic [15:0] mem [logic [15:0]];
  logic [39:0] sh;
  logic [15:0] ob;
  int          n, oc;
  logic        wip = 0, wel = 0, wpen = 0;
  logic [1:0]  bp = 0;

  // Data line starts at a known level
  initial miso = 1'b0;

  always @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      if (n == 40 && sh[39:32] == 8'h02 && wel) begin
        mem[sh[31:16]] = sh[15:0];
        wip = 1;
        wel = 0;
      end
      if (n == 16 && sh[15:8] == 8'h01 && wel) begin
        {wpen, bp} = {sh[7], sh[3:2]};
        wel = 0;
      end
      n = 0;
      oc = 0;
    end else begin
      sh = {sh[38:0], mosi};
      n++;
      if (n == 8 && sh[7:0] == 8'h06) wel = 1;
      if (n == 8 && sh[7:0] == 8'h04) wel = 0;
      if (n == 8 && sh[7:0] == 8'h05) begin
        ob = {wpen, 3'h0, bp, wel, wip, 8'h00};
        oc = 8;
      end
      if (n == 24 && sh[23:16] == 8'h03) begin
        ob = mem.exists(sh[15:0]) ? mem[sh[15:0]] : ~sh[15:0];
        oc = 16;
      end
    end
  end
  // Released line toggles so a stale bit never passes for data
  always @(negedge sck or posedge cs_n) begin
    if (!cs_n && oc > 0) begin
      miso = ob[15];
      ob = ob << 1;
      oc--;
    end else miso = ~miso;
  end
  always @(posedge wip) #40000 wip = 0;
endmodule

// ### test/tb.sv
// Self-checking bench of the serial EEPROM access controller
`timescale 1ns/1ps
module tb;
  import seac_pkg::*;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic        hready, hresp, irq, ee_miso, sck_d, cs_d;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, sub_ids, r, v;
  logic [31:0] sh = 32'h60, seed = 32'h08a3e187;
  logic [39:0] fr;
  seac_pins_s  ee_pins;
  int          nb, per, rise, cyc, mismatches, total_checks;

  always #10 hclk = ~hclk;
  seac_ctrl DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .ee_pins(ee_pins), .ee_miso(ee_miso), .sub_ids(sub_ids), .irq(irq));
  seac_ee_model EE (.sck(ee_pins.sck), .cs_n(ee_pins.cs_n),
    .mosi(ee_pins.mosi), .miso(ee_miso));

  // Wire monitor: bits at sck rise, sck period in core cycles
  always @(posedge hclk) begin
    sck_d <= ee_pins.sck;
    cs_d <= ee_pins.cs_n;
    cyc <= cyc + 1;
    if (cs_d && !ee_pins.cs_n) nb <= 0;
    if (ee_pins.sck && !sck_d) begin
      fr <= {fr[38:0], ee_pins.mosi};
      nb <= nb + 1;
      per <= cyc - rise;
      rise <= cyc;
    end
    if (cyc == 60000) begin
      mismatches++;
      report_and_stop();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Word the far side holds: only word 0 was written
  function automatic logic [15:0] ee_word(input logic [15:0] a);
    return (a == 16'h0) ? 16'h5a3c : ~a;
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One whole-word transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task automatic cmd(input logic [2:0] c);
    bus(1, 8'ha0, {sh[31:4], c, 1'b1});
    do bus(0, 8'ha0, 0); while (r[0] !== 1'b0);
  endtask

  task automatic rst();
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask

  task automatic autoload();
    sh[5] = 1'b0;
    bus(1, 8'ha0, sh);
    do bus(0, 8'hd0, 0); while (r[1] !== 1'b1);
    bus(0, 8'ha0, 0);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    rst();
    bus(0, 8'ha0, 0);
    chk(r, 32'h60);
    chk(hresp, 1'b0);
    bus(0, 8'ha4, 0);
    chk(r, 0);
    bus(0, 8'h80, 0);
    chk(r, 0);
    bus(0, 8'hd0, 0);
    chk(r, 0);
    v = rnd();
    bus(1, 8'ha4, v);
    bus(0, 8'ha4, 0);
    chk(r, v);
    $display("test reset values done");
    bus(1, 8'hd4, 32'h1);
    cmd(3'h6);
    chk({nb[7:0], fr[7:0]}, {8'd8, 8'h06});
    chk(per, 64);
    chk(irq, 1'b1);
    bus(0, 8'hd0, 0);
    chk(r, 1);
    repeat (2) @(posedge hclk);
    chk(irq, 1'b0);
    $display("test write enable done");
    cmd(3'h5);
    chk(r[9:8], 2'b10);
    sh[15:10] = 6'b100001;
    cmd(3'h1);
    chk({nb[7:0], fr[15:0]}, {8'd16, 16'h0184});
    sh[15:10] = 6'b0;
    cmd(3'h5);
    chk(r[15:8], 8'h84);
    $display("test status register done");
    cmd(3'h6);
    bus(1, 8'ha4, 32'h5a3c_0000);
    cmd(3'h2);
    chk({nb[7:0], fr}, {8'd40, 8'h02, 32'h0000_5a3c});
    cmd(3'h5);
    chk(r[9:8], 2'b01);
    do cmd(3'h5); while (r[8] !== 1'b0);
    for (int i = 0; i < 2; i++) begin
      v = rnd();
      if (i == 0) v[15:0] = 16'h0;
      bus(1, 8'ha4, v);
      cmd(3'h3);
      chk({nb[7:0], fr[39:16]}, {8'd40, 8'h03, v[15:0]});
      bus(0, 8'ha4, 0);
      chk(r, {ee_word(v[15:0]), v[15:0]});
    end
    $display("test data write and read done");
    cmd(3'h6);
    cmd(3'h4);
    chk({nb[7:0], fr[7:0]}, {8'd8, 8'h04});
    cmd(3'h5);
    chk(r[9], 1'b0);
    bus(0, 8'hd0, 0);
    v = nb;
    cmd(3'h0);
    bus(0, 8'hd0, 0);
    chk({nb[7:0], r[7:0]}, {v[7:0], 8'h01});
    sh[7:6] = 2'b11;
    cmd(3'h6);
    chk(per, 4);
    sh[7:6] = 2'b01;
    $display("test disable, refusal and rate done");
    autoload();
    chk(r[4], 1'b1);
    bus(0, 8'hb4, 0);
    chk({r, sub_ids}, {2{32'hfffd_fffe}});
    sh[5] = 1'b1;
    rst();
    cmd(3'h6);
    bus(1, 8'ha4, 32'h1234_0000);
    cmd(3'h2);
    do cmd(3'h5); while (r[8] !== 1'b0);
    autoload();
    chk({r[4], sub_ids}, 33'h0);
    $display("test autoload done");
    report_and_stop();
  end
endmodule

// ### verilog/seac_ctrl.sv
// AHB-Lite register slave and serial engine for the configuration EEPROM
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "seac_regs.svh"

// Contract
// - start bit launches one EEPROM access; codes 000 and 111 launch none, clear start and set the done flag
// - code 010 writes data, 011 reads
// - code 001 writes, 101 reads status register
// - code 110 write-enable, 100 write-disable
// - autoload status set only after success
// - autoload disable bit suppresses autoload
// - rate 01 divides core clock by 64
// - busy-writing bit mirrors EEPROM status
// - write-enable-latch bit mirrors EEPROM status
// - block protect bits exchanged with status
// - write-protect-enable bit, reset zero
// - data field holds write/read word
// - autoload replaces subsystem identifier defaults
module seac_ctrl
  import seac_pkg::*;
#(
  // Autoload signature word, value arbitrary
  parameter logic [15:0] AL_SIGNATURE = 16'h5a3c
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Serial EEPROM link
  output seac_pins_s       ee_pins,
  input  wire logic        ee_miso,
  // Loaded identifiers and interrupt
  output logic      [31:0] sub_ids,
  output logic             irq
);

  seac_state_s s_q;
  seac_state_s s_d;
  logic        take;
  logic        go;
  logic [2:0]  go_cmd;
  logic [15:0] go_addr;
  logic [5:0]  half_m1;
  logic [5:0]  bits_nx;

  function automatic logic [5:0] cmd_len(input logic [2:0] c);
    case (c)
      `SEAC_CMD_WRSR,
      `SEAC_CMD_RDSR:  cmd_len = `SEAC_LEN_SR;
      `SEAC_CMD_WRITE,
      `SEAC_CMD_READ:  cmd_len = `SEAC_LEN_DATA;
      `SEAC_CMD_WREN,
      `SEAC_CMD_WRDI:  cmd_len = `SEAC_LEN_OP;
      default:         cmd_len = `SEAC_LEN_NONE;
    endcase
  endfunction

  always_comb begin
    s_d     = s_q;
    go      = 1'b0;
    go_cmd  = s_q.cmd;
    go_addr = s_q.addr;
    take    = hsel & hready & htrans[1];
    bits_nx = 6'(s_q.bits + 6'h01);
    if (s_q.rate == `SEAC_RATE_TEST)
      half_m1 = 6'((`SEAC_DIV_TEST >> 1) - 7'h01);
    else
      half_m1 = 6'((`SEAC_DIV_NORM >> 1) - 7'h01);

    // Data-in synchroniser, accepted when stages two and three agree
    s_d.sync = {s_q.sync[1:0], ee_miso};
    if (s_q.sync[1] == s_q.sync[2])
      s_d.miso = s_q.sync[2];

    // Address phase; reads get one wait state
    s_d.wr_p  = take & hwrite;
    s_d.rd_p  = take & ~hwrite;
    s_d.ready = ~(take & ~hwrite);
    if (take)
      s_d.a = haddr[7:0];

    // Write data phase
    if (s_q.wr_p) begin
      case (s_q.a)
        `SEAC_OFS_CTRL: begin
          if (s_q.st == SEAC_ST_IDLE && !s_q.start && !s_q.al_busy) begin
            s_d.start = hwdata[`SEAC_B_START];
            s_d.cmd   = hwdata[`SEAC_F_CMD];
          end
          s_d.al_dis = hwdata[`SEAC_B_AL_DIS];
          s_d.rate   = hwdata[`SEAC_F_RATE];
          s_d.bp     = hwdata[`SEAC_F_BP];
          s_d.wpen   = hwdata[`SEAC_B_WPEN];
        end
        `SEAC_OFS_ADDR: begin
          s_d.addr = hwdata[`SEAC_F_ADDR];
          s_d.data = hwdata[`SEAC_F_DATA];
        end
        `SEAC_OFS_IMASK: s_d.imask = hwdata[1:0];
        default: ;
      endcase
    end

    // Read data phase; interrupt status register clears on read
    if (s_q.rd_p) begin
      s_d.rdata = 32'h0000_0000;
      case (s_q.a)
        `SEAC_OFS_CTRL: begin
          s_d.rdata[`SEAC_B_START]  = s_q.start;
          s_d.rdata[`SEAC_F_CMD]    = s_q.cmd;
          s_d.rdata[`SEAC_B_AL_OK]  = s_q.al_ok;
          s_d.rdata[`SEAC_B_AL_DIS] = s_q.al_dis;
          s_d.rdata[`SEAC_F_RATE]   = s_q.rate;
          s_d.rdata[`SEAC_B_WIP]    = s_q.wip;
          s_d.rdata[`SEAC_B_WEL]    = s_q.wel;
          s_d.rdata[`SEAC_F_BP]     = s_q.bp;
          s_d.rdata[`SEAC_F_STHI]   = s_q.sthi;
          s_d.rdata[`SEAC_B_WPEN]   = s_q.wpen;
        end
        `SEAC_OFS_ADDR:  s_d.rdata = {s_q.data, s_q.addr};
        `SEAC_OFS_IDS:   s_d.rdata = {s_q.ssid, s_q.ssvid};
        `SEAC_OFS_ISTAT: begin
          s_d.rdata[1:0] = s_q.istat;
          s_d.istat      = 2'h0;
        end
        `SEAC_OFS_IMASK: s_d.rdata[1:0] = s_q.imask;
        default: ;
      endcase
    end

    // Serial engine
    unique case (s_q.st)
      SEAC_ST_IDLE: begin
        if (s_q.al_busy) begin
          go      = 1'b1;
          go_cmd  = `SEAC_CMD_READ;
          go_addr = {14'h0000, s_q.al_ph};
        end else if (s_q.start) begin
          if (cmd_len(s_q.cmd) == `SEAC_LEN_NONE) begin
            s_d.start                = 1'b0;
            s_d.istat[`SEAC_I_DONE] = 1'b1;
          end else begin
            go = 1'b1;
          end
        end else if (!s_q.al_dis && !s_q.al_tried) begin
          s_d.al_busy  = 1'b1;
          s_d.al_tried = 1'b1;
          s_d.al_ph    = 2'h0;
        end
      end
      SEAC_ST_XFER: begin
        s_d.cnt = 6'(s_q.cnt + 6'h01);
        if (s_q.cnt == half_m1) begin
          s_d.cnt = 6'h00;
          if (!s_q.pins.sck) begin
            s_d.pins.sck = 1'b1;
            s_d.rx       = {s_q.rx[14:0], s_q.miso};
          end else begin
            s_d.pins.sck  = 1'b0;
            s_d.bits      = bits_nx;
            s_d.tx        = {s_q.tx[38:0], 1'b0};
            s_d.pins.mosi = s_q.tx[38];
            if (bits_nx == s_q.nbits) begin
              s_d.st        = SEAC_ST_IDLE;
              s_d.pins.cs_n = 1'b1;
              s_d.pins.mosi = 1'b0;
              if (s_q.al_busy) begin
                s_d.al_ph = 2'(s_q.al_ph + 2'h1);
                unique case (s_q.al_ph)
                  2'h0: begin
                    if (s_q.rx != AL_SIGNATURE) begin
                      s_d.al_busy            = 1'b0;
                      s_d.istat[`SEAC_I_AL] = 1'b1;
                    end
                  end
                  2'h1: s_d.ssvid = s_q.rx;
                  default: begin
                    s_d.ssid               = s_q.rx;
                    s_d.al_ok              = 1'b1;
                    s_d.al_busy            = 1'b0;
                    s_d.istat[`SEAC_I_AL] = 1'b1;
                  end
                endcase
              end else begin
                s_d.start                = 1'b0;
                s_d.istat[`SEAC_I_DONE] = 1'b1;
                if (s_q.xcmd == `SEAC_CMD_READ)
                  s_d.data = s_q.rx;
                if (s_q.xcmd == `SEAC_CMD_RDSR) begin
                  s_d.wip  = s_q.rx[0];
                  s_d.wel  = s_q.rx[1];
                  s_d.bp   = s_q.rx[3:2];
                  s_d.sthi = s_q.rx[6:4];
                  s_d.wpen = s_q.rx[7];
                end
              end
            end
          end
        end
      end
    endcase

    // Launch: opcode first, then address, then data, MSB first
    if (go) begin
      s_d.st        = SEAC_ST_XFER;
      s_d.xcmd      = go_cmd;
      s_d.nbits     = cmd_len(go_cmd);
      s_d.cnt       = 6'h00;
      s_d.bits      = 6'h00;
      s_d.pins.cs_n = 1'b0;
      s_d.pins.sck  = 1'b0;
      if (go_cmd == `SEAC_CMD_WRSR)
        s_d.tx = {5'h00, go_cmd, s_q.wpen, s_q.sthi, s_q.bp, 2'h0,
                  24'h00_0000};
      else if (go_cmd == `SEAC_CMD_WRITE)
        s_d.tx = {5'h00, go_cmd, go_addr, s_q.data};
      else if (go_cmd == `SEAC_CMD_READ)
        s_d.tx = {5'h00, go_cmd, go_addr, 16'h0000};
      else
        s_d.tx = {5'h00, go_cmd, 32'h0000_0000};
      s_d.pins.mosi = s_d.tx[39];
    end

    s_d.irq = |(s_d.istat & s_d.imask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q           <= '0;
      s_q.st        <= SEAC_ST_IDLE;
      s_q.al_dis    <= `SEAC_RST_AL_DIS;
      s_q.rate      <= `SEAC_RST_RATE;
      s_q.addr      <= `SEAC_RST_WORD;
      s_q.data      <= `SEAC_RST_WORD;
      s_q.pins.cs_n <= 1'b1;
      s_q.ready     <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata    = s_q.rdata;
  assign hreadyout = s_q.ready;
  assign hresp     = 1'b0;
  assign ee_pins   = s_q.pins;
  assign sub_ids   = {s_q.ssid, s_q.ssvid};
  assign irq       = s_q.irq;

  // Checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  start_launch_a: assert property (
    s_q.st == SEAC_ST_IDLE && s_q.start && !s_q.al_busy
      && cmd_len(s_q.cmd) != `SEAC_LEN_NONE
    |=> s_q.st == SEAC_ST_XFER && !s_q.pins.cs_n && s_q.xcmd == $past(s_q.cmd)
  ) else $error("start did not launch a transfer");

  opcode_sent_a: assert property (
    $rose(s_q.st == SEAC_ST_XFER)
    |-> s_q.tx[39:32] == {5'h00, s_q.xcmd} && s_q.pins.mosi == 1'b0
  ) else $error("opcode not loaded at launch");

  status_len_a: assert property (
    $rose(s_q.st == SEAC_ST_XFER)
      && (s_q.xcmd == `SEAC_CMD_WRSR || s_q.xcmd == `SEAC_CMD_RDSR)
    |-> s_q.nbits == `SEAC_LEN_SR
  ) else $error("status access has wrong length");

  latch_len_a: assert property (
    $rose(s_q.st == SEAC_ST_XFER)
      && (s_q.xcmd == `SEAC_CMD_WREN || s_q.xcmd == `SEAC_CMD_WRDI)
    |-> s_q.nbits == `SEAC_LEN_OP
  ) else $error("latch command has wrong length");

  autoload_ok_a: assert property (
    $rose(s_q.al_ok) |-> $past(s_q.al_busy) && $past(s_q.al_ph) == `SEAC_AL_LAST
  ) else $error("autoload status set without autoload");

  autoload_off_a: assert property (
    s_q.al_dis && !s_q.al_busy |=> !s_q.al_busy
  ) else $error("autoload ran while disabled");

  sck_divide_a: assert property (
    $rose(s_q.pins.sck) && s_q.rate == `SEAC_RST_RATE
      && $stable(s_q.rate)
    |-> ##31 s_q.pins.sck ##1 !s_q.pins.sck
  ) else $error("serial clock high time is not half of 64");

  wip_mirror_a: assert property (
    s_q.st == SEAC_ST_XFER && s_d.st == SEAC_ST_IDLE && !s_q.al_busy
      && s_q.xcmd == `SEAC_CMD_RDSR
    |=> s_q.wip == $past(s_q.rx[0]) && s_q.wel == $past(s_q.rx[1])
  ) else $error("status bits not mirrored");

  wrsr_bits_a: assert property (
    $rose(s_q.st == SEAC_ST_XFER) && s_q.xcmd == `SEAC_CMD_WRSR
    |-> s_q.tx[27:26] == s_q.bp && s_q.tx[31] == s_q.wpen
  ) else $error("status write carries wrong bits");

  write_data_a: assert property (
    $rose(s_q.st == SEAC_ST_XFER) && s_q.xcmd == `SEAC_CMD_WRITE
      && !s_q.al_busy
    |-> s_q.tx[15:0] == s_q.data && s_q.tx[31:16] == s_q.addr
  ) else $error("write frame does not carry address and data");

  ids_source_a: assert property (
    !$stable(s_q.ssid) || !$stable(s_q.ssvid) |-> $past(s_q.al_busy)
  ) else $error("identifier changed outside autoload");

  // A valid command may only drop start as its frame ends
  start_clear_a: assert property (
    $fell(s_q.start)
    |-> $past(s_q.st) == SEAC_ST_XFER
      || cmd_len($past(s_q.cmd)) == `SEAC_LEN_NONE
  ) else $error("start cleared before completion");

  read_update_a: assert property (
    s_q.st == SEAC_ST_XFER && s_d.st == SEAC_ST_IDLE && !s_q.al_busy
      && s_q.xcmd == `SEAC_CMD_READ
    |=> s_q.data == $past(s_q.rx) && !s_q.start
  ) else $error("read data not stored");

  read_wait_a: assert property (
    take && !hwrite |=> !hreadyout ##1 hreadyout
  ) else $error("read wait state wrong");

endmodule

// ### verilog/seac_pkg.sv
// Types of the serial EEPROM access controller
package seac_pkg;

  typedef enum logic [1:0] {
    SEAC_ST_IDLE = 2'b01,
    SEAC_ST_XFER = 2'b10
  } seac_st_e;

  typedef struct packed {
    logic sck;
    logic cs_n;
    logic mosi;
  } seac_pins_s;

  typedef struct packed {
    seac_st_e    st;
    logic        start;
    logic [2:0]  cmd;
    logic        al_ok;
    logic        al_dis;
    logic [1:0]  rate;
    logic        wip;
    logic        wel;
    logic [1:0]  bp;
    logic [2:0]  sthi;
    logic        wpen;
    logic [15:0] addr;
    logic [15:0] data;
    logic [15:0] ssvid;
    logic [15:0] ssid;
    logic [1:0]  istat;
    logic [1:0]  imask;
    logic        al_busy;
    logic        al_tried;
    logic [1:0]  al_ph;
    logic [2:0]  xcmd;
    logic [5:0]  cnt;
    logic [5:0]  bits;
    logic [5:0]  nbits;
    logic [39:0] tx;
    logic [15:0] rx;
    seac_pins_s  pins;
    logic [2:0]  sync;
    logic        miso;
    logic        wr_p;
    logic        rd_p;
    logic [7:0]  a;
    logic [31:0] rdata;
    logic        ready;
    logic        irq;
  } seac_state_s;

endpackage

// ### verilog/seac_regs.svh
// Register map, field positions, codes and counts of the EEPROM controller
`ifndef SEAC_REGS_SVH
`define SEAC_REGS_SVH

// Byte offsets on the register bus
`define SEAC_OFS_CTRL    8'ha0
`define SEAC_OFS_ADDR    8'ha4
`define SEAC_OFS_IDS     8'hb4
`define SEAC_OFS_ISTAT   8'hd0
`define SEAC_OFS_IMASK   8'hd4

// Control/status word fields
`define SEAC_B_START     0
`define SEAC_F_CMD       3:1
`define SEAC_B_AL_OK     4
`define SEAC_B_AL_DIS    5
`define SEAC_F_RATE      7:6
`define SEAC_B_WIP       8
`define SEAC_B_WEL       9
`define SEAC_F_BP        11:10
`define SEAC_F_STHI      14:12
`define SEAC_B_WPEN      15

// Address/data word fields
`define SEAC_F_ADDR      15:0
`define SEAC_F_DATA      31:16

// Reset values
`define SEAC_RST_AL_DIS  1'h1
`define SEAC_RST_RATE    2'h1
`define SEAC_RST_WORD    16'h0000

// Command codes, equal to the serial opcodes
`define SEAC_CMD_WRSR    3'h1
`define SEAC_CMD_WRITE   3'h2
`define SEAC_CMD_READ    3'h3
`define SEAC_CMD_WRDI    3'h4
`define SEAC_CMD_RDSR    3'h5
`define SEAC_CMD_WREN    3'h6

// Serial clock: core clock divided by these
`define SEAC_RATE_TEST   2'h3
`define SEAC_DIV_NORM    7'h40
`define SEAC_DIV_TEST    7'h04

// Frame lengths in bits
`define SEAC_LEN_NONE    6'h00
`define SEAC_LEN_OP      6'h08
`define SEAC_LEN_SR      6'h10
`define SEAC_LEN_DATA    6'h28

// Autoload: word indices, last one carries the subsystem id
`define SEAC_AL_LAST     2'h2

// Interrupt bits
`define SEAC_I_DONE      0
`define SEAC_I_AL        1

`endif
